/* clk_sync.v */
// Behaviour
// - The clock pin is only pulled low or released, and sync starts at the first falling clock edge after the clock is enabled for arbitration.
// - A falling clock line edge from any device restarts our low count.
// - After the clock goes low we hold it low until our low count ends.
// - When our low count ends with STRETCH_I low we release and wait, not counting high while the line stays low.
// - When the line is sensed high we start counting our high period.
// - When our high count ends first we pull the line low, restarting everyone's low count.
// - A transmitted data bit stays stable for a minimum delay after each falling clock.
// - When stretching, the next data bit goes out only while over 157 cycles of low count remain, which the 163-cycle fast low never allows after the hold delay.
// - A new start is held off until the bus has been free for 4.7 us or 1.3 us after a stop.
// - Clock and data outputs only pull low or release, never drive high.
module clk_sync #(
    parameter CW = 16
) (
    input  wire          CLK_SYS_I,
    input  wire          RESET_I,
    input  wire          ENABLE_I,
    input  wire          FAST_MODE_I,
    input  wire          STRETCH_I,
    input  wire          TX_BIT_I,
    input  wire          TX_EN_I,
    input  wire          START_REQ_I,
    input  wire          SCL_I,
    input  wire          SDA_I,
    output wire          SCL_O,
    output wire          SCL_OE_O,
    output wire          SDA_O,
    output wire          SDA_OE_O,
    output wire          SCL_FALL_O,
    output wire          BUS_FREE_O,
    output wire          START_OK_O
);
`include "clk_sync_defs.vh"

    localparam ST_IDLE = 4'b0001;
    localparam ST_LOW  = 4'b0010;
    localparam ST_WAIT = 4'b0100;
    localparam ST_HIGH = 4'b1000;

    // Cycle counts cut to counter width once, here
    localparam [CW-1:0] LOW_F_CYC  = `LOW_FAST_CYC;
    localparam [CW-1:0] LOW_S_CYC  = `LOW_STD_CYC;
    localparam [CW-1:0] HIGH_F_CYC = `HIGH_FAST_CYC;
    localparam [CW-1:0] HIGH_S_CYC = `HIGH_STD_CYC;
    localparam [CW-1:0] FREE_F_CYC = `BUS_FREE_FAST_CYC;
    localparam [CW-1:0] FREE_S_CYC = `BUS_FREE_STD_CYC;
    localparam [CW-1:0] HOLD_CYC   = `DATA_HOLD_CYC;
    localparam [CW-1:0] LEAD_CYC   = `DATA_LEAD_CYC;
    localparam [CW-1:0] ONE_CYC    = 1;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg  scl_m_q, scl_s_q, scl_p_q;
    reg  sda_m_q, sda_s_q, sda_p_q;

    // Two stages before any logic looks at the pins
    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= SCL_I;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= SDA_I;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    wire scl_fall = scl_p_q & ~scl_s_q;
    wire scl_rise = ~scl_p_q & scl_s_q;
    wire stop_seen = scl_s_q & ~sda_p_q & sda_s_q;
    wire start_seen = scl_s_q & sda_p_q & ~sda_s_q;

    // ----------------------------------------
    // Period selection
    // ----------------------------------------
    function [CW-1:0] pick;
        input          fast;
        input [CW-1:0] f_cyc;
        input [CW-1:0] s_cyc;
        begin
            pick = fast ? f_cyc : s_cyc;
        end
    endfunction

    wire [CW-1:0] low_cyc  = pick(FAST_MODE_I, LOW_F_CYC,
                                  LOW_S_CYC);
    wire [CW-1:0] high_cyc = pick(FAST_MODE_I, HIGH_F_CYC,
                                  HIGH_S_CYC);
    wire [CW-1:0] free_cyc = pick(FAST_MODE_I, FREE_F_CYC,
                                  FREE_S_CYC);

    // ----------------------------------------
    // Clock low/high state machine
    // ----------------------------------------
    reg [3:0]    state_q, state_d;
    reg [CW-1:0] cnt_q, cnt_d;
    reg          scl_pull_q, scl_pull_d;

    // Pin is sampled late by the synchroniser, so counts run a few
    // cycles long; that only lengthens the minimum times.
    always @* begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        scl_pull_d = scl_pull_q;
        case (state_q)
        ST_IDLE: begin
            scl_pull_d = 1'b0;
            if (ENABLE_I && scl_fall) begin
                state_d    = ST_LOW;
                cnt_d      = low_cyc;
                scl_pull_d = 1'b1;
            end
        end
        ST_LOW: begin
            scl_pull_d = 1'b1;
            if (cnt_q > 1)
                cnt_d = cnt_q - 1'b1;
            else if (!STRETCH_I) begin
                state_d    = ST_WAIT;
                scl_pull_d = 1'b0;
            end
        end
        ST_WAIT: begin
            scl_pull_d = 1'b0;
            if (scl_rise || scl_s_q) begin
                state_d = ST_HIGH;
                cnt_d   = high_cyc;
            end
        end
        ST_HIGH: begin
            if (scl_fall) begin
                state_d    = ST_LOW;
                cnt_d      = low_cyc;
                scl_pull_d = 1'b1;
            end else if (cnt_q > 1)
                cnt_d = cnt_q - 1'b1;
            else begin
                state_d    = ST_LOW;
                cnt_d      = low_cyc;
                scl_pull_d = 1'b1;
            end
        end
        default: begin
            state_d    = ST_IDLE;
            scl_pull_d = 1'b0;
        end
        endcase
        if (!ENABLE_I) begin
            state_d    = ST_IDLE;
            scl_pull_d = 1'b0;
        end
    end

    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            state_q    <= ST_IDLE;
            cnt_q      <= {CW{1'b0}};
            scl_pull_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            scl_pull_q <= scl_pull_d;
        end
    end

    // ----------------------------------------
    // Data hold and early data placement
    // ----------------------------------------
    reg [CW-1:0] hold_q;
    reg          sda_pull_q;

    // Data may only change once the hold delay after a fall has run out
    // and, when stretching, while enough low time remains before release.
    // Synced pin lags the wire, so data only moves while we ourselves
    // hold the clock low, with at least one held cycle still to come.
    wire lead_ok = !STRETCH_I || (cnt_q > LEAD_CYC);
    wire own_low = (state_q == ST_LOW) && (cnt_q > ONE_CYC);
    // Our own pull is a fall too, seen before the synced edge arrives
    wire own_fall = scl_pull_d && !scl_pull_q;
    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            hold_q     <= {CW{1'b0}};
            sda_pull_q <= 1'b0;
        end else begin
            if (scl_fall || own_fall)
                hold_q <= HOLD_CYC;
            else if (hold_q != 0)
                hold_q <= hold_q - 1'b1;
            if (!TX_EN_I)
                sda_pull_q <= 1'b0;
            else if (own_low && !scl_fall && hold_q == 0 && lead_ok)
                sda_pull_q <= ~TX_BIT_I;
        end
    end

    // ----------------------------------------
    // Bus free timer
    // ----------------------------------------
    reg [CW-1:0] free_q;
    reg          busy_q;

    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            busy_q <= 1'b0;
            free_q <= {CW{1'b0}};
        end else begin
            if (start_seen || scl_fall)
                busy_q <= 1'b1;
            else if (stop_seen) begin
                busy_q <= 1'b0;
                free_q <= free_cyc;
            end else if (!busy_q && free_q != 0)
                free_q <= free_q - 1'b1;
        end
    end

    assign BUS_FREE_O = !busy_q && free_q == 0;
    assign START_OK_O = START_REQ_I && BUS_FREE_O;
    assign SCL_FALL_O = scl_fall;

    // Open-drain: value always low, only the enable moves
    assign SCL_O    = 1'b0;
    assign SCL_OE_O = scl_pull_q;
    assign SDA_O    = 1'b0;
    assign SDA_OE_O = sda_pull_q;
endmodule

/* clk_sync_defs.vh */
`ifndef CLK_SYNC_DEFS_VH
`define CLK_SYNC_DEFS_VH
// ----------------------------------------
// Timing figures and derived cycle counts
// ----------------------------------------
`define SYS_CLK_MHZ        125
`define LOW_STD_NS         4700
`define LOW_FAST_NS        1300
`define HIGH_STD_NS        4000
`define HIGH_FAST_NS       600
`define BUS_FREE_STD_NS    4700
`define BUS_FREE_FAST_NS   1300
`define DATA_HOLD_NS       300
`define RISE_STD_NS        1000
`define SETUP_STD_NS       250
// Least times round up to whole cycles
`define NS_TO_CYC_UP(ns)   (((ns) * `SYS_CLK_MHZ + 999) / 1000)
`define LOW_STD_CYC        `NS_TO_CYC_UP(`LOW_STD_NS)
`define LOW_FAST_CYC       `NS_TO_CYC_UP(`LOW_FAST_NS)
`define HIGH_STD_CYC       `NS_TO_CYC_UP(`HIGH_STD_NS)
`define HIGH_FAST_CYC      `NS_TO_CYC_UP(`HIGH_FAST_NS)
`define BUS_FREE_STD_CYC   `NS_TO_CYC_UP(`BUS_FREE_STD_NS)
`define BUS_FREE_FAST_CYC  `NS_TO_CYC_UP(`BUS_FREE_FAST_NS)
`define DATA_HOLD_CYC      `NS_TO_CYC_UP(`DATA_HOLD_NS)
`define DATA_LEAD_CYC      `NS_TO_CYC_UP(`RISE_STD_NS + `SETUP_STD_NS)
`endif

/* far_master.sv */
module far_master (
    input  wire         clk_i,
    input  wire         en_i,
    input  wire         scl_i,
    input  wire  [15:0] lo_i,
    input  wire  [15:0] hi_i,
    output logic        oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] cnt_q;
    logic        wt_q;
    // Peer master: only pulls low or lets go, like a real open drain
    always @(posedge clk_i) begin
        cnt_q <= cnt_q + 16'h0001;
        if (!en_i) begin
            {oe_o, wt_q, cnt_q} <= 18'h00000;
        end else if (oe_o) begin
            {oe_o, wt_q} <= (cnt_q < lo_i) ? 2'h2 : 2'h1;
        end else if (wt_q) begin
            {wt_q, cnt_q} <= {~scl_i, 16'h0000};
        end else if (!scl_i || cnt_q >= hi_i) begin
            {oe_o, cnt_q} <= {1'b1, 16'h0000};
        end
    end
endmodule

/* clk_sync_chk.sv */
module clk_sync_chk #(parameter CW = 16) (
    input wire CLK_SYS_I, RESET_I, ENABLE_I, FAST_MODE_I, STRETCH_I,
    input wire TX_BIT_I, TX_EN_I, START_REQ_I, SCL_I, SDA_I, SCL_O,
    input wire SCL_OE_O, SDA_O, SDA_OE_O, SCL_FALL_O, BUS_FREE_O,
    input wire START_OK_O
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [CW-1:0] lo_q, hi_q, fa_q;
    // Our pull and raw pin run lengths, so sync delay only adds slack
    always @(posedge CLK_SYS_I) begin
        lo_q <= (RESET_I | ~SCL_OE_O) ? '0 : lo_q + 1'b1;
        hi_q <= (RESET_I | ~SCL_I) ? '0 : hi_q + 1'b1;
        fa_q <= (RESET_I | $fell(SCL_I)) ? '0 : fa_q + (fa_q != '1);
    end
    // Everything lives on the system clock
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RESET_I);
    a_pull_only: assert property (!SCL_O && !SDA_O)
        else $error("pin driven high");
    a_fall_pulls: assert property (SCL_FALL_O && ENABLE_I
        |=> ##[0:1] SCL_OE_O) else $error("no pull after fall");
    a_low_held: assert property ($fell(SCL_OE_O) && ENABLE_I
        |-> lo_q >= (FAST_MODE_I ? 163 : 588)) else $error("low short");
    a_high_count: assert property ($rose(SCL_OE_O)
        |-> $past(SCL_FALL_O) || $past(SCL_FALL_O, 2)
        || hi_q >= (FAST_MODE_I ? 75 : 500)) else $error("high short");
    a_data_hold: assert property ($changed(SDA_OE_O) && TX_EN_I
        |-> !SCL_I && fa_q >= 38) else $error("data moved early");
    a_start_gate: assert property (
        START_OK_O == (START_REQ_I && BUS_FREE_O)) else $error("bad gate");
    a_free_wait: assert property ($rose(BUS_FREE_O)
        |-> $past(SDA_I, 100) && $past(SCL_I, 100)) else $error("early");
    a_off_release: assert property (!ENABLE_I |-> ##2 !SCL_OE_O)
        else $error("clock held while off");
    c_low: cover property ($fell(SCL_OE_O));
    c_data: cover property ($changed(SDA_OE_O));
    c_free: cover property ($rose(BUS_FREE_O));
endmodule

bind clk_sync clk_sync_chk #(.CW(CW)) chk (.*);

/* clk_sync_tb.sv */
module clk_sync_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LF = (1300 + 7) / 8, HF = (600 + 7) / 8;
    localparam int LS = (4700 + 7) / 8, HS = (4000 + 7) / 8;
    logic        clk = 1'b0, rst = 1'b1, en = 1'b0, fast = 1'b1;
    logic        tx = 1'b0, pull = 1'b0;
    logic [15:0] plo = 16'h0000, phi = 16'h0000;
    wire         scl_oe, sda_oe, p_oe, free, ok;
    wire         scl = ~(scl_oe | p_oe);
    wire         sda = ~(sda_oe | pull);
    int          n_mismatch = 0, num_checks = 0;

    clk_sync uut (.CLK_SYS_I(clk), .RESET_I(rst), .ENABLE_I(en),
        .FAST_MODE_I(fast), .STRETCH_I(1'b0), .TX_BIT_I(tx),
        .TX_EN_I(1'b1), .START_REQ_I(1'b1), .SCL_I(scl), .SDA_I(sda),
        .SCL_O(), .SCL_OE_O(scl_oe), .SDA_O(), .SDA_OE_O(sda_oe),
        .SCL_FALL_O(), .BUS_FREE_O(free), .START_OK_O(ok));
    far_master peer (.clk_i(clk), .en_i(en), .scl_i(scl), .lo_i(plo),
        .hi_i(phi), .oe_o(p_oe));

    initial forever #4 clk = ~clk;

    // Range compare; an unknown never counts as inside
    task automatic chk(input logic [15:0] got, input int exp, input int tol);
        num_checks++;
        if ((got >= exp && got <= exp + tol) !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask

    // One synced period against the peer, then switch both off
    task automatic cfg(input logic f, input int lo, hi, el, eh);
        int k, a, b;
        {fast, tx, en} <= {f, ~tx, 1'b1};
        plo <= lo[15:0];
        phi <= hi[15:0];
        for (k = 0; k < 4000 && scl !== 1'b0; k++) @(posedge clk);
        for (a = 0; a < 4000 && scl === 1'b0; a++) @(posedge clk);
        for (b = 0; b < 4000 && scl === 1'b1; b++) @(posedge clk);
        chk(a[15:0], el, 6);
        chk(b[15:0], eh, 6);
        chk({15'h0000, sda_oe}, {31'h0, ~tx}, 0);
        en <= 1'b0;
        repeat (4) @(posedge clk);
        chk({15'h0000, scl_oe}, 0, 0);
    endtask

    // Start then stop with the clock idle; free flag must lag the stop
    task automatic bus_free();
        pull <= 1'b1;
        repeat (10) @(posedge clk);
        pull <= 1'b0;
        repeat (500) @(posedge clk);
        chk({14'h0000, free, ok}, 0, 0);
        repeat (100) @(posedge clk);
        chk({14'h0000, free, ok}, 3, 0);
    endtask

    task automatic test_done();
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({14'h0000, free, sda_oe}, 2, 0);
        cfg(1'b1, 40, 300, LF, HF);
        cfg(1'b1, 300, 30, 300, 30);
        cfg(1'b0, 40, 900, LS, HS);
        bus_free();
        test_done();
    end
endmodule
